// [pkg/adapter_pkg.sv]
////////////////////////////////////////////////////////////////
// Shared constants of the dual parallel adapter
////////////////////////////////////////////////////////////////
package adapter_pkg;

  // Port width
  localparam int PORT_W = 8;

  // Register select codes
  localparam logic [1:0] ADDR_A_PORT = 2'h0;
  localparam logic [1:0] ADDR_A_CTL = 2'h1;
  localparam logic [1:0] ADDR_B_PORT = 2'h2;
  localparam logic [1:0] ADDR_B_CTL = 2'h3;

  // Control register bit positions
  localparam int BIT_EN1 = 0;
  localparam int BIT_POL1 = 1;
  localparam int BIT_SEL = 2;
  localparam int BIT_EN2 = 3;
  localparam int BIT_POL2 = 4;
  localparam int BIT_MODE2 = 5;
  localparam int BIT_FLAG2 = 6;
  localparam int BIT_FLAG1 = 7;

  // Values after reset
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [5:0] RST_CTL = 6'h00;
  localparam logic RST_LINE = 1'b1;

  // Synchroniser width of the bus and of the peripheral pins
  localparam int BUS_SYNC_W = 15;
  localparam int PIN_SYNC_W = 20;

endpackage

// [rtl/parallel_adapter.sv]
`timescale 1ns/1ps
// Function
// [R01] Direction bit 1 output, 0 input
// [R02] Selected only when hi, hi, low
// [R03] Reset clears every register and flag
// [R04] Transfers timed by processor phase-2 clock
// [R05] Read/write high reads, low writes
// [R06] Control bit 2 picks output or direction
// [R07] Addresses: A port, A ctl, B port, B ctl
// [R08] All six registers writable
// [R09] Control and direction reads return contents
// [R10] Request outputs active low, open drain
// [R11] Flags bits 7, 6 gated by enables
// [R12] First A input sets bit 7, enable 0
// [R13] Second A input sets bit 6, enable 3
// [R14] Port A read clears both A flags
// [R15] Side B interrupts same as side A
// [R16] Port B read clears both B flags
// [R17] Bit 1 picks first input edge
// [R18] Bit 5 low: input, edge by bit 4
// [R19] Strobe mode pulses on port A read
// [R20] Port A read returns pin levels
// [R21] Side B input lines undriven
// [R22] Data bus driven only during selected read
// [R23] Strobe low at fall, high next fall
// [R24] Handshake high again on first-input edge
// [R25] Bits 5, 4 set: line follows bit 3
// [R26] Side B strobes triggered by writes
// [R27] Output mode: bit 6 reads zero
// [R28] Write data captured high, applied at fall
// [R29] Port B read: output reg for outputs
// [R30] Control inputs synchronised and edge-detected
module parallel_adapter (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Processor bus
  input wire logic phi2_i,
  input wire logic rw_i,
  input wire logic select_hi_first_i,
  input wire logic select_hi_second_i,
  input wire logic select_low_n_i,
  input wire logic reg_sel_lo_i,
  input wire logic reg_sel_hi_i,
  input wire logic [7:0] cpu_data_bus_i,
  output logic [7:0] cpu_data_bus_o,
  output logic cpu_data_bus_oe_n_o,
  // Interrupt requests
  output logic side_a_irq_n_o,
  output logic side_a_irq_oe_n_o,
  output logic side_b_irq_n_o,
  output logic side_b_irq_oe_n_o,
  // Side A peripheral pins
  input wire logic [7:0] port_a_pins_i,
  output logic [7:0] port_a_pins_o,
  output logic [7:0] port_a_pins_oe_n_o,
  input wire logic side_a_event_in_i,
  input wire logic side_a_ctl_line_i,
  output logic side_a_ctl_line_o,
  output logic side_a_ctl_line_oe_n_o,
  // Side B peripheral pins
  input wire logic [7:0] port_b_pins_i,
  output logic [7:0] port_b_pins_o,
  output logic [7:0] port_b_pins_oe_n_o,
  input wire logic side_b_event_in_i,
  input wire logic side_b_ctl_line_i,
  output logic side_b_ctl_line_o,
  output logic side_b_ctl_line_oe_n_o
);

  ////////////////////////////////////////////////////////////////
  // Declarations

  // Synchronised bus levels
  logic [adapter_pkg::BUS_SYNC_W-1:0] bus_lvl;
  // Bus edges, phase-2 fall used
  logic [adapter_pkg::BUS_SYNC_W-1:0] bus_fall;
  // Synchronised peripheral levels
  logic [adapter_pkg::PIN_SYNC_W-1:0] pin_lvl;
  // Peripheral rising edges
  logic [adapter_pkg::PIN_SYNC_W-1:0] pin_rise;
  // Peripheral falling edges
  logic [adapter_pkg::PIN_SYNC_W-1:0] pin_fall;

  // Decoded current bus fields
  logic phi2_s;
  logic phi2_fall;
  logic rw_s;
  logic sel_s;
  logic [1:0] addr_s;
  logic [7:0] wdata_s;

  // Bus fields held from the high phase
  logic rw_l_r;
  logic sel_l_r;
  logic [1:0] addr_l_r;
  logic [7:0] wdata_l_r;

  // Per-side storage
  logic [1:0][7:0] dir_r;
  logic [1:0][7:0] out_r;
  logic [1:0][5:0] ctl_r;
  logic [1:0] flag1_r;
  logic [1:0] flag2_r;
  logic [1:0] line_r;
  logic [1:0] line_oe_n_r;
  logic [1:0] irq_n_r;
  logic [1:0][7:0] pin_oe_n_r;

  // Per-side views
  logic [1:0][7:0] pins_s;
  logic [1:0] ev_rise;
  logic [1:0] ev_fall;
  logic [1:0] ctl_rise;
  logic [1:0] ctl_fall;
  logic [1:0][7:0] ctl_view;
  logic [1:0][7:0] port_view;

  // Read data path
  logic [7:0] rdata_nxt;
  logic [7:0] rdata_r;
  logic rd_oe_n_r;

  ////////////////////////////////////////////////////////////////
  // Input synchronisers

  // [R04] Bus sampled on system clock
  pin_sync #(
    .W(adapter_pkg::BUS_SYNC_W)
  ) u_bus_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i({phi2_i, rw_i, select_hi_first_i, select_hi_second_i,
              select_low_n_i, reg_sel_hi_i, reg_sel_lo_i, cpu_data_bus_i}),
    .level_o(bus_lvl),
    .rise_o(),
    .fall_o(bus_fall)
  );

  // [R30] Control inputs synchronised, edge-detected
  pin_sync #(
    .W(adapter_pkg::PIN_SYNC_W)
  ) u_pin_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i({side_b_event_in_i, side_a_event_in_i,
              side_b_ctl_line_i, side_a_ctl_line_i,
              port_b_pins_i, port_a_pins_i}),
    .level_o(pin_lvl),
    .rise_o(pin_rise),
    .fall_o(pin_fall)
  );

  ////////////////////////////////////////////////////////////////
  // Bus field decode
  always_comb begin
    phi2_s = bus_lvl[14];
    phi2_fall = bus_fall[14];
    rw_s = bus_lvl[13];
    // [R02] Two high selects, one low select
    sel_s = bus_lvl[12] & bus_lvl[11] & ~bus_lvl[10];
    addr_s = bus_lvl[9:8];
    wdata_s = bus_lvl[7:0];
  end

  // Split peripheral levels per side
  always_comb begin
    pins_s[0] = pin_lvl[7:0];
    pins_s[1] = pin_lvl[15:8];
    ctl_rise = pin_rise[17:16];
    ctl_fall = pin_fall[17:16];
    ev_rise = pin_rise[19:18];
    ev_fall = pin_fall[19:18];
  end

  ////////////////////////////////////////////////////////////////
  // Bus latch for the high phase
  // [R28] Data captured while phase-2 high
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rw_l_r <= 1'b0;
      sel_l_r <= 1'b0;
      addr_l_r <= 2'h0;
      wdata_l_r <= adapter_pkg::RST_BYTE;
    end else if (phi2_s) begin
      // Track the bus while the phase is high
      rw_l_r <= rw_s;
      sel_l_r <= sel_s;
      addr_l_r <= addr_s;
      wdata_l_r <= wdata_s;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Per-side logic
  for (genvar i = 0; i < 2; i++) begin : g_side
    // Addresses of this side
    localparam logic [1:0] PORT_ADDR =
      (i == 0) ? adapter_pkg::ADDR_A_PORT : adapter_pkg::ADDR_B_PORT;
    localparam logic [1:0] CTL_ADDR =
      (i == 0) ? adapter_pkg::ADDR_A_CTL : adapter_pkg::ADDR_B_CTL;

    // Access strobes at the phase-2 fall
    logic acc;
    logic port_rd;
    logic port_wr;
    logic ctl_wr;
    logic trig;
    logic act1;
    logic act2;
    logic in_mode;

    // Access decode
    always_comb begin
      acc = phi2_fall & sel_l_r;
      // [R07] Port address with control bit 2
      port_rd = acc & rw_l_r & (addr_l_r == PORT_ADDR) &
                ctl_r[i][adapter_pkg::BIT_SEL];
      // [R05] Low level writes
      port_wr = acc & ~rw_l_r & (addr_l_r == PORT_ADDR);
      ctl_wr = acc & ~rw_l_r & (addr_l_r == CTL_ADDR);
      // [R26] Side B strobe on output write
      trig = (i == 0) ? port_rd
                      : port_wr & ctl_r[i][adapter_pkg::BIT_SEL];
      // [R17] First input edge polarity
      act1 = ctl_r[i][adapter_pkg::BIT_POL1] ? ev_rise[i] : ev_fall[i];
      // [R18] Second line edge polarity
      act2 = ctl_r[i][adapter_pkg::BIT_POL2] ? ctl_rise[i] : ctl_fall[i];
      in_mode = ~ctl_r[i][adapter_pkg::BIT_MODE2];
    end

    // Register writes
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        // [R03] All registers cleared
        dir_r[i] <= adapter_pkg::RST_BYTE;
        out_r[i] <= adapter_pkg::RST_BYTE;
        ctl_r[i] <= adapter_pkg::RST_CTL;
      end else begin
        // [R06] Bit 2 steers output or direction
        if (port_wr && ctl_r[i][adapter_pkg::BIT_SEL]) begin
          out_r[i] <= wdata_l_r;
        end else if (port_wr) begin
          dir_r[i] <= wdata_l_r;
        end
        // [R08] Control writes, flags excluded
        if (ctl_wr) begin
          ctl_r[i] <= wdata_l_r[5:0];
        end
      end
    end

    // Interrupt flags
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        flag1_r[i] <= 1'b0;
        flag2_r[i] <= 1'b0;
      end else begin
        // [R12] First input always sets bit 7
        if (act1) begin
          flag1_r[i] <= 1'b1;
        end else if (port_rd) begin
          // [R14] Port read clears flag
          flag1_r[i] <= 1'b0;
        end
        // [R13] Second input sets bit 6
        if (act2 && in_mode) begin
          flag2_r[i] <= 1'b1;
        end else if (port_rd) begin
          // [R16] Port read clears flag
          flag2_r[i] <= 1'b0;
        end
      end
    end

    // Second control line driver
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        line_r[i] <= adapter_pkg::RST_LINE;
        line_oe_n_r[i] <= 1'b1;
      end else begin
        line_oe_n_r[i] <= in_mode;
        if (in_mode) begin
          // Undriven level kept high
          line_r[i] <= adapter_pkg::RST_LINE;
        end else if (ctl_r[i][adapter_pkg::BIT_POL2]) begin
          // [R25] Line follows bit 3
          line_r[i] <= ctl_r[i][adapter_pkg::BIT_EN2];
        end else if (trig) begin
          // [R19] Low at the fall ending the access
          line_r[i] <= 1'b0;
        end else if (ctl_r[i][adapter_pkg::BIT_EN2]) begin
          // [R23] High again on next fall
          if (phi2_fall) begin
            line_r[i] <= 1'b1;
          end
        end else if (act1) begin
          // [R24] Handshake ends on first-input edge
          line_r[i] <= 1'b1;
        end
      end
    end

    // Request and pin enables
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        irq_n_r[i] <= 1'b1;
        pin_oe_n_r[i] <= 8'hff;
      end else begin
        // [R11] Flag with enable pulls request
        irq_n_r[i] <= ~((flag1_r[i] & ctl_r[i][adapter_pkg::BIT_EN1]) |
                        (flag2_r[i] & in_mode &
                         ctl_r[i][adapter_pkg::BIT_EN2]));
        // [R01] Direction bit 1 drives the pin
        pin_oe_n_r[i] <= ~dir_r[i];
      end
    end

    // Read views of this side
    always_comb begin
      // [R27] Bit 6 zero in output mode
      ctl_view[i] = {flag1_r[i], flag2_r[i] & in_mode, ctl_r[i]};
      if (i == 0) begin
        // [R20] Side A returns pin levels
        port_view[i] = pins_s[i];
      end else begin
        // [R29] Outputs from register, inputs from pins
        port_view[i] = (out_r[i] & dir_r[i]) | (pins_s[i] & ~dir_r[i]);
      end
    end
  end

  ////////////////////////////////////////////////////////////////
  // Read data multiplexer
  always_comb begin
    rdata_nxt = adapter_pkg::RST_BYTE;
    case (addr_s)
      // [R09] Direction read when bit 2 clear
      adapter_pkg::ADDR_A_PORT: begin
        rdata_nxt = ctl_r[0][adapter_pkg::BIT_SEL] ? port_view[0] : dir_r[0];
      end
      adapter_pkg::ADDR_A_CTL: begin
        rdata_nxt = ctl_view[0];
      end
      adapter_pkg::ADDR_B_PORT: begin
        rdata_nxt = ctl_r[1][adapter_pkg::BIT_SEL] ? port_view[1] : dir_r[1];
      end
      adapter_pkg::ADDR_B_CTL: begin
        rdata_nxt = ctl_view[1];
      end
      default: begin
        rdata_nxt = adapter_pkg::RST_BYTE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Data bus driver
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rdata_r <= adapter_pkg::RST_BYTE;
      rd_oe_n_r <= 1'b1;
    end else begin
      rdata_r <= rdata_nxt;
      // [R22] Drive only in selected read phase
      rd_oe_n_r <= ~(phi2_s & sel_s & rw_s);
    end
  end

  ////////////////////////////////////////////////////////////////
  // Output ports, all from flip-flops or constants
  always_comb begin
    cpu_data_bus_o = rdata_r;
    cpu_data_bus_oe_n_o = rd_oe_n_r;
    // [R10] Open drain: low value, enabled when active
    side_a_irq_n_o = 1'b0;
    side_a_irq_oe_n_o = irq_n_r[0];
    side_b_irq_n_o = 1'b0;
    side_b_irq_oe_n_o = irq_n_r[1];
    port_a_pins_o = out_r[0];
    port_a_pins_oe_n_o = pin_oe_n_r[0];
    // [R21] Side B inputs released
    port_b_pins_o = out_r[1];
    port_b_pins_oe_n_o = pin_oe_n_r[1];
    // [R15] Side B mirrors side A
    side_a_ctl_line_o = line_r[0];
    side_a_ctl_line_oe_n_o = line_oe_n_r[0];
    side_b_ctl_line_o = line_r[1];
    side_b_ctl_line_oe_n_o = line_oe_n_r[1];
  end

endmodule

// [rtl/pin_sync.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// Two-stage synchroniser with edge detection
////////////////////////////////////////////////////////////////
module pin_sync #(
  parameter int W = 8
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Asynchronous levels
  input wire logic [W-1:0] async_i,
  // Synchronised level and edges
  output logic [W-1:0] level_o,
  output logic [W-1:0] rise_o,
  output logic [W-1:0] fall_o
);

  // First stage, read only by the second
  logic [W-1:0] meta_r;
  // Second stage, the usable level
  logic [W-1:0] sync_r;
  // Previous usable level
  logic [W-1:0] prev_r;

  ////////////////////////////////////////////////////////////////
  // Synchroniser chain
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_r <= '0;
      sync_r <= '0;
      prev_r <= '0;
    end else begin
      meta_r <= async_i;
      sync_r <= meta_r;
      prev_r <= sync_r;
    end
  end

  ////////////////////////////////////////////////////////////////
  // Edges against the previous sample
  always_comb begin
    level_o = sync_r;
    rise_o = sync_r & ~prev_r;
    fall_o = ~sync_r & prev_r;
  end

endmodule

// [tb/adapter_checker.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// Bus, request and pin timing checks
module adapter_checker (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Processor bus
  input wire logic phi2_i,
  input wire logic rw_i,
  input wire logic select_hi_first_i,
  input wire logic select_hi_second_i,
  input wire logic select_low_n_i,
  input wire logic cpu_data_bus_oe_n_o,
  // Requests and pins
  input wire logic side_a_irq_n_o,
  input wire logic side_a_irq_oe_n_o,
  input wire logic side_b_irq_n_o,
  input wire logic side_b_irq_oe_n_o,
  input wire logic [7:0] port_a_pins_o,
  input wire logic [7:0] port_a_pins_oe_n_o,
  input wire logic [7:0] port_b_pins_o,
  input wire logic [7:0] port_b_pins_oe_n_o,
  input wire logic side_a_ctl_line_o
);
  // Chip selected
  wire logic sel;
  assign sel = select_hi_first_i && select_hi_second_i && !select_low_n_i;
  default clocking dc @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // Selected read held four clocks
  sequence s_rd_held;
    (phi2_i && rw_i && sel) [*4];
  endsequence
  // Unselected for four clocks
  sequence s_idle;
    (!sel) [*4];
  endsequence
  property p_rd_drive;
    s_rd_held |-> !cpu_data_bus_oe_n_o;
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("bus not driven in read");
  property p_unsel;
    s_idle |-> cpu_data_bus_oe_n_o;
  endproperty
  a_unsel: assert property (p_unsel) else $error("bus driven while unselected");
  property p_oe_cause;
    !cpu_data_bus_oe_n_o |-> $past(phi2_i && rw_i, 3);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("bus driven without read");
  property p_irq_pins;
    !side_a_irq_n_o && !side_b_irq_n_o;
  endproperty
  a_irq_pins: assert property (p_irq_pins) else $error("request pin driven high");
  property p_side_a_irq_n_rel;
    $rose(side_a_irq_oe_n_o) |-> !$past(phi2_i, 1) && !$past(phi2_i, 2);
  endproperty
  a_side_a_irq_n_rel: assert property (p_side_a_irq_n_rel) else $error("A request freed early");
  property p_side_b_irq_n_rel;
    $rose(side_b_irq_oe_n_o) |-> !$past(phi2_i, 1) && !$past(phi2_i, 2);
  endproperty
  a_side_b_irq_n_rel: assert property (p_side_b_irq_n_rel) else $error("B request freed early");
  property p_pa_commit;
    $changed({port_a_pins_o, port_a_pins_oe_n_o}) |-> !$past(phi2_i, 1) && !$past(phi2_i, 2);
  endproperty
  a_pa_commit: assert property (p_pa_commit) else $error("port A changed in phase");
  property p_pb_commit;
    $changed({port_b_pins_o, port_b_pins_oe_n_o}) |-> !$past(phi2_i, 1) && !$past(phi2_i, 2);
  endproperty
  a_pb_commit: assert property (p_pb_commit) else $error("port B changed in phase");
  property p_cta_fall;
    $fell(side_a_ctl_line_o) |-> !$past(phi2_i, 1);
  endproperty
  a_cta_fall: assert property (p_cta_fall) else $error("A line fell in phase");
endmodule

bind parallel_adapter adapter_checker chk_u (.*);

// [tb/parallel_adapter_test.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// Self-checking bench of the parallel adapter
module parallel_adapter_test;
  // Design inputs, set at time zero
  logic clk_i = 1'h0, rst_n_i = 1'h0, phi2_i = 1'h0, rw_i = 1'h1;
  logic reg_sel_lo_i = 1'h0, reg_sel_hi_i = 1'h0, select_low_n_i = 1'h1;
  logic select_hi_first_i = 1'h0, select_hi_second_i = 1'h0;
  logic [7:0] cpu_data_bus_i = 8'h00, ext_a = 8'h00, ext_b = 8'h00;
  logic [1:0] ext_c = 2'h0, ev = 2'h0;
  // Design outputs and resolved wires
  logic [7:0] cpu_data_bus_o, port_a_pins_o, port_a_pins_oe_n_o, port_a_pins_i;
  logic [7:0] port_b_pins_o, port_b_pins_oe_n_o, port_b_pins_i;
  logic cpu_data_bus_oe_n_o, side_a_irq_n_o, side_a_irq_oe_n_o;
  logic side_b_irq_n_o, side_b_irq_oe_n_o, side_a_ctl_line_o, side_a_ctl_line_oe_n_o;
  logic side_b_ctl_line_o, side_b_ctl_line_oe_n_o;
  logic [1:0] irq_w, ctl_w;
  logic [7:0] q, c, da, db, oa, ob;
  integer seed = 79, miscompares = 0, check_count = 0, cyc = 0, i;

  always #20 clk_i = ~clk_i;

  parallel_adapter dut_u (.*, .side_a_event_in_i(ev[0]), .side_b_event_in_i(ev[1]),
    .side_a_ctl_line_i(ctl_w[0]), .side_b_ctl_line_i(ctl_w[1]));

  periph_model far_u (
    .a_ext_i(ext_a),
    .b_ext_i(ext_b),
    .c_ext_i(ext_c),
    .pa_i(port_a_pins_o),
    .pa_oe_n_i(port_a_pins_oe_n_o),
    .pb_i(port_b_pins_o),
    .pb_oe_n_i(port_b_pins_oe_n_o),
    .c_i({side_b_ctl_line_o, side_a_ctl_line_o}),
    .c_oe_n_i({side_b_ctl_line_oe_n_o, side_a_ctl_line_oe_n_o}),
    .irq_i({side_b_irq_n_o, side_a_irq_n_o}),
    .irq_oe_n_i({side_b_irq_oe_n_o, side_a_irq_oe_n_o}),
    .pa_o(port_a_pins_i),
    .pb_o(port_b_pins_i),
    .c_o(ctl_w),
    .irq_o(irq_w)
  );

  // Expected port read: register where output, pin where input
  function automatic logic [7:0] mix(input logic [7:0] d, o, p);
    return (d & o) | (~d & p);
  endfunction

  // Verdict and end of run
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Byte comparison
  task automatic ck(input string n, input logic [7:0] e, g);
    check_count++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask

  // One phase-2 cycle, read data kept in q
  task automatic bus(input logic r, input logic [1:0] a, input logic [7:0] d, input logic s);
    @(posedge clk_i);
    rw_i <= r;
    {reg_sel_hi_i, reg_sel_lo_i} <= a;
    cpu_data_bus_i <= d;
    select_hi_first_i <= 1'h1;
    select_hi_second_i <= 1'h1;
    select_low_n_i <= ~s;
    phi2_i <= 1'h1;
    repeat (5) @(posedge clk_i);
    #1 q = cpu_data_bus_o;
    if (r && s) ck("drive", 8'h00, {7'h00, cpu_data_bus_oe_n_o});
    @(posedge clk_i);
    phi2_i <= 1'h0;
    repeat (6) @(posedge clk_i);
  endtask

  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    bus(1'h0, a, d, 1'h1);
  endtask

  task automatic rd(input logic [1:0] a);
    bus(1'h1, a, 8'h00, 1'h1);
  endtask

  // Hang guard
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test;
    end
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rst_n_i <= 1'h1;
    repeat (4) @(posedge clk_i);
    for (i = 0; i < 4; i++) begin
      rd(i[1:0]);
      ck("reset", 8'h00, q);
    end
    // Random directions, outputs and pin levels
    for (i = 0; i < 6; i++) begin
      da = 8'($random(seed));
      db = 8'($random(seed));
      oa = 8'($random(seed));
      ob = 8'($random(seed));
      if (i < 2) da = {8{i[0]}};
      ext_a <= 8'($random(seed));
      ext_b <= 8'($random(seed));
      wr(2'h1, 8'h00);
      wr(2'h3, 8'h00);
      wr(2'h0, da);
      wr(2'h2, db);
      rd(2'h0);
      ck("dir_a", da, q);
      rd(2'h2);
      ck("dir_b", db, q);
      wr(2'h1, 8'h04);
      wr(2'h3, 8'h04);
      wr(2'h0, oa);
      wr(2'h2, ob);
      ck("oe_a", ~da, port_a_pins_oe_n_o);
      ck("oe_b", ~db, port_b_pins_oe_n_o);
      rd(2'h0);
      ck("pin_a", mix(da, oa, ext_a), q);
      rd(2'h2);
      ck("pin_b", mix(db, ob, ext_b), q);
      bus(1'h0, 2'h1, 8'h3b, 1'h0);
      rd(2'h1);
      ck("unsel", 8'h04, q);
    end
    // Edge flags, masking and clearing on both sides and polarities
    for (i = 0; i < 4; i++) begin
      c = {3'h0, i[0], 2'h3, i[0], i[0]};
      wr({i[1], 1'h1}, c);
      ev[i[1]] <= ~i[0];
      ext_c[i[1]] <= ~i[0];
      repeat (8) @(posedge clk_i);
      rd({i[1], 1'h0});
      ev[i[1]] <= i[0];
      repeat (8) @(posedge clk_i);
      rd({i[1], 1'h1});
      ck("flag_first", c | 8'h80, q);
      ck("irq_first", {7'h00, ~i[0]}, {7'h00, irq_w[i[1]]});
      ext_c[i[1]] <= i[0];
      repeat (8) @(posedge clk_i);
      rd({i[1], 1'h1});
      ck("flag_second", c | 8'hc0, q);
      ck("irq_second", 8'h00, {7'h00, irq_w[i[1]]});
      rd({i[1], 1'h0});
      rd({i[1], 1'h1});
      ck("cleared", c, q);
      ck("irq_free", 8'h01, {7'h00, irq_w[i[1]]});
    end
    ck("line_in", 8'h03, {6'h00, side_b_ctl_line_oe_n_o, side_a_ctl_line_oe_n_o});
    // Read strobe on side A
    wr(2'h1, 8'h2c);
    rd(2'h0);
    ck("strobe_low", 8'h00, {7'h00, side_a_ctl_line_o});
    rd(2'h1);
    ck("no_flag", 8'h2c, q);
    ck("strobe_high", 8'h01, {7'h00, side_a_ctl_line_o});
    // Handshake freed by a falling first input
    wr(2'h1, 8'h24);
    rd(2'h0);
    ck("hs_low", 8'h00, {7'h00, side_a_ctl_line_o});
    ev[0] <= 1'h0;
    repeat (8) @(posedge clk_i);
    ck("hs_high", 8'h01, {7'h00, side_a_ctl_line_o});
    for (i = 0; i < 2; i++) begin
      wr(2'h1, 8'h34 | {4'h0, i[0], 3'h0});
      ck("manual", {7'h00, i[0]}, {7'h00, side_a_ctl_line_o});
    end
    // Write strobe on side B
    wr(2'h3, 8'h2c);
    ck("line_out", 8'h00, {6'h00, side_b_ctl_line_oe_n_o, side_a_ctl_line_oe_n_o});
    wr(2'h2, 8'h5a);
    ck("wstrobe_low", 8'h00, {7'h00, side_b_ctl_line_o});
    rd(2'h3);
    ck("wstrobe_high", 8'h01, {7'h00, side_b_ctl_line_o});
    end_of_test;
  end
endmodule

// [tb/periph_model.sv]
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////
// Peripheral side: resolves the shared lines
module periph_model (
  // Values the peripheral drives
  input wire logic [7:0] a_ext_i,
  input wire logic [7:0] b_ext_i,
  input wire logic [1:0] c_ext_i,
  // Adapter drive and enables
  input wire logic [7:0] pa_i,
  input wire logic [7:0] pa_oe_n_i,
  input wire logic [7:0] pb_i,
  input wire logic [7:0] pb_oe_n_i,
  input wire logic [1:0] c_i,
  input wire logic [1:0] c_oe_n_i,
  input wire logic [1:0] irq_i,
  input wire logic [1:0] irq_oe_n_i,
  // Resolved wires
  output logic [7:0] pa_o,
  output logic [7:0] pb_o,
  output logic [1:0] c_o,
  output logic [1:0] irq_o
);
  assign pa_o = (pa_oe_n_i & a_ext_i) | (~pa_oe_n_i & pa_i);
  assign pb_o = (pb_oe_n_i & b_ext_i) | (~pb_oe_n_i & pb_i);
  assign c_o = (c_oe_n_i & c_ext_i) | (~c_oe_n_i & c_i);
  assign irq_o = irq_oe_n_i | irq_i;
endmodule
